// ===== sscc_core.sv
// Purpose: Synchronous serial channel, master or slave, one shift clock
// Assumes: Pins are synchronised here; bytes on a plain register port
// Notes: Frame width 1..8 bits; baud generator shared by both modes
//
// How it works
// [RQ1] Transmitter always samples its own input pin
// [RQ2] Idle stations keep drivers off or send ones; an enabled core keeps its data driver on when idle and sends out_bit_q
// [RQ3] Buffer-free pulse when buffer enters shift register
// [RQ4] Reloaded buffer starts next frame without gap
// [RQ5] Longer frames only as width multiples
// [RQ6] Mode picks pin directions and data lines
// [RQ7] Own 16-bit down counter with reload
// [RQ8] Reload reads live count while enabled
// [RQ9] Software never writes reload while enabled
// [RQ10] Shift rate is clock over 2(reload+1)
// [RQ11] Reload zero only in master mode
// [RQ12] Sticky error flags, enables gate error line
// [RQ13] Unread receive buffer overwritten, overrun flagged
// [RQ14] Data change near latch edge flags phase
// [RQ15] Half-clock full duplex reports phase fault
// [RQ16] Slave clock rate off by two flags
// [RQ17] Rate fault with overrun enable resets channel
// [RQ18] Rate checker expects next pulse after frame
// [RQ19] Slave frame on stale buffer flags stale
// [RQ20] Unselected open-drain slaves load all ones
// [RQ21] Push-pull slaves reload buffer every frame
// [RQ22] Width 2..8, words right aligned; the width field also gives 1
// [RQ23] Frame end fills receive buffer, pulses done
// [RQ24] Idle level and shift edge selectable
// [RQ25] Underflow reloads and toggles master clock
module sscc_core
    import sscc_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Serial pins, each as input, output and enable
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    // Interrupt lines
    output logic TX_FREE_IRQ,
    output logic RX_DONE_IRQ,
    output logic ERROR_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    sscc_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [11:0] ctrl_q;
    logic [3:0] err_q;
    logic [15:0] reload_q, cnt_q;
    logic [7:0] tx_buf_q, rx_buf_q, shift_q, rdata_q;
    logic tx_full_q, tx_new_q, rx_unread_q, busy_q;
    logic [3:0] bits_q;
    logic mclk_q;
    logic out_bit_q;
    logic [2:0] sclk_sync_q, miso_sync_q, mosi_sync_q;
    logic [1:0] after_q;
    logic rate_seen_q;
    logic [16:0] gap_q;

    wire en = ctrl_q[SSCC_C_EN];
    wire master = ctrl_q[SSCC_C_MASTER];
    wire msb_first_sel = ctrl_q[SSCC_C_MSB];
    wire clock_edge_sel = ctrl_q[SSCC_C_PH];
    wire idle_level_sel = ctrl_q[SSCC_C_PO];
    wire [3:0] width = {1'b0, ctrl_q[SSCC_C_WHI:SSCC_C_WLO]} + 4'h1;
    wire [3:0] err_en = ctrl_q[SSCC_C_TEN:SSCC_C_REN];

    wire wr_ctrl_lo = req.wr && req.addr == SSCC_ADR_CTRL;
    wire wr_ctrl_hi = req.wr && req.addr == SSCC_ADR_STAT;
    wire wr_tx = req.wr && req.addr == SSCC_ADR_TX;
    wire rd_rx = req.rd && req.addr == SSCC_ADR_RX;
    wire wr_brl = req.wr && req.addr == SSCC_ADR_BRL && !en;
    wire wr_brh = req.wr && req.addr == SSCC_ADR_BRH && !en;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 0 read only by stage 1
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_sync_q <= 3'h0;
            miso_sync_q <= 3'h0;
            mosi_sync_q <= 3'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], SCLK_I};
            miso_sync_q <= {miso_sync_q[1:0], MISO_I};
            mosi_sync_q <= {mosi_sync_q[1:0], MOSI_I};
        end
    end

    // Data input by mode; a sender hears its own line in half duplex
    wire [2:1] din_sync = master ? miso_sync_q[2:1] // RQ6 RQ1
                                 : mosi_sync_q[2:1];

    ////////////////////////////////////////////////////////////////////////
    // Baud generator and edge events
    wire under = en && cnt_q == 16'h0000; // RQ10 RQ11
    wire [15:0] cnt_d = (!en || under) ? reload_q : cnt_q - 16'h0001;
    // Master clock stands at idle level outside frames
    wire mclk_d = !(en && busy_q) ? 1'b0 : (under ? !mclk_q : mclk_q); // RQ25

    // Slave clock normalised to idle-low, edges seen on synced copies
    wire s_now = sclk_sync_q[1] ^ idle_level_sel;
    wire s_old = sclk_sync_q[2] ^ idle_level_sel;
    wire s_lead = en && !master && s_now && !s_old;
    wire s_trail = en && !master && !s_now && s_old;
    wire m_lead = en && master && busy_q && under && !mclk_q;
    wire m_trail = en && master && busy_q && under && mclk_q;
    wire lead = m_lead || s_lead;
    wire trail = m_trail || s_trail;
    // Leading edge shifts when clock_edge_sel is 0, latches otherwise
    wire latch_ev = clock_edge_sel ? lead : trail; // RQ24
    wire shift_ev = clock_edge_sel ? trail : lead; // RQ24

    ////////////////////////////////////////////////////////////////////////
    // Frame control
    wire in_bit = din_sync[1];
    wire last_latch = busy_q && latch_ev && bits_q == width - 4'h1;
    wire [7:0] rx_word = {shift_q[6:0], in_bit};
    wire load_now = tx_full_q && (!busy_q || last_latch); // RQ4
    // Slave starts on first clock edge; stale if no new word loaded
    wire slave_start = !master && en && !busy_q && (s_lead || s_trail);
    wire stale = slave_start && !tx_full_q && !tx_new_q; // RQ19

    // Shift register holds bits in send order, msb first internally
    function automatic logic [7:0] order(input logic [7:0] w,
                                         input logic [3:0] n,
                                         input logic msb);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                r[7 - i] = msb ? w[n - 1 - i] : w[i];
            end
        end
        return r;
    endfunction : order

    function automatic logic [7:0] unorder(input logic [7:0] s,
                                           input logic [3:0] n,
                                           input logic msb);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                r[msb ? i : n - 1 - i] = s[i];
            end
        end
        return r;
    endfunction : unorder // RQ22

    // Transmit word rearranged into send order
    wire [7:0] load_word = order(tx_buf_q, width, msb_first_sel); // RQ22

    ////////////////////////////////////////////////////////////////////////
    // Phase check: change one cycle before to two after latch edge
    wire din_change = din_sync[1] ^ din_sync[2];
    logic before_q;
    wire phase_hit = busy_q && ((latch_ev && (din_change || before_q))
                     || (after_q != 2'h0 && din_change)); // RQ14 RQ15

    ////////////////////////////////////////////////////////////////////////
    // Slave rate check: gap between slave edges vs one half period
    wire [16:0] half = {1'b0, reload_q} + 17'h00001;
    wire s_edge = s_lead || s_trail;
    wire rate_hit = en && !master && rate_seen_q &&
                    ((s_edge && gap_q < {1'b0, half[16:1]}) ||
                     (gap_q > {half[15:0], 1'b0})); // RQ16 RQ18
    wire auto_reset = rate_hit && err_en[0]; // RQ17

    wire [3:0] err_set = {stale, rate_hit, phase_hit,
                          last_latch && rx_unread_q}; // RQ13

    ////////////////////////////////////////////////////////////////////////
    // Control and baud registers
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= SSCC_CTRL_RST;
            reload_q <= SSCC_BRL_RST;
            cnt_q <= SSCC_BRL_RST;
            mclk_q <= 1'b0;
        end else begin
            if (wr_ctrl_lo) ctrl_q[7:0] <= req.wdata;
            if (wr_ctrl_hi) ctrl_q[11:8] <= req.wdata[7:4];
            if (wr_brl) reload_q[7:0] <= req.wdata; // RQ9
            if (wr_brh) reload_q[15:8] <= req.wdata; // RQ7
            cnt_q <= cnt_d; // RQ7
            mclk_q <= mclk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error flags: set wins over software clear
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            err_q <= 4'h0;
        end else if (wr_ctrl_hi) begin
            err_q <= (err_q & req.wdata[3:0]) | err_set; // RQ12
        end else begin
            err_q <= err_q | err_set; // RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit buffer and frame engine
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_buf_q <= SSCC_BYTE_RST;
            tx_full_q <= 1'b0;
            tx_new_q <= 1'b0;
            shift_q <= SSCC_BYTE_RST;
            busy_q <= 1'b0;
            bits_q <= 4'h0;
            out_bit_q <= 1'b0;
        end else if (auto_reset || !en) begin
            busy_q <= 1'b0;
            bits_q <= 4'h0;
            if (wr_tx) begin
                tx_buf_q <= req.wdata;
                tx_full_q <= 1'b1;
            end
        end else begin
            if (wr_tx) begin
                tx_buf_q <= req.wdata;
                tx_full_q <= 1'b1;
            end else if (load_now) begin
                tx_full_q <= 1'b0; // RQ3
            end
            if (load_now) begin
                shift_q <= load_word; // RQ4
                out_bit_q <= load_word[7];
                tx_new_q <= 1'b1;
                bits_q <= 4'h0;
                busy_q <= master;
            end else if (last_latch) begin
                busy_q <= 1'b0;
                bits_q <= 4'h0;
                shift_q <= rx_word;
                tx_new_q <= 1'b0;
            end else if (slave_start) begin
                busy_q <= 1'b1;
                if (stale) begin
                    out_bit_q <= shift_q[7]; // RQ19
                end
            end
            if (busy_q && latch_ev && !last_latch) begin
                shift_q <= rx_word; // RQ1
                bits_q <= bits_q + 4'h1;
            end
            if (busy_q && shift_ev && bits_q != 4'h0) begin
                out_bit_q <= shift_q[7];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer, phase window and rate counter
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_buf_q <= SSCC_BYTE_RST;
            rx_unread_q <= 1'b0;
            after_q <= 2'h0;
            before_q <= 1'b0;
            rate_seen_q <= 1'b0;
            gap_q <= 17'h00000;
        end else begin
            if (last_latch) begin
                rx_buf_q <= unorder(rx_word, width, msb_first_sel); // RQ23
                rx_unread_q <= 1'b1; // RQ13
            end else if (rd_rx) begin
                rx_unread_q <= 1'b0;
            end
            before_q <= din_change;
            if (latch_ev) begin
                after_q <= SSCC_PH_AFTER;
            end else if (after_q != 2'h0) begin
                after_q <= after_q - SSCC_PH_BEFORE;
            end
            if (!en || master || auto_reset) begin
                rate_seen_q <= 1'b0;
                gap_q <= 17'h00000;
            end else if (s_edge) begin
                rate_seen_q <= 1'b1; // RQ18
                gap_q <= 17'h00000;
            end else if (gap_q != 17'h1FFFF) begin
                gap_q <= gap_q + 17'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    logic [7:0] rsel;
    always_comb begin
        unique case (req.addr)
            SSCC_ADR_CTRL: rsel = ctrl_q[7:0];
            SSCC_ADR_STAT: rsel = {ctrl_q[11:8], err_q};
            SSCC_ADR_TX: rsel = {7'h00, busy_q};
            SSCC_ADR_RX: rsel = rx_buf_q;
            SSCC_ADR_BRL: rsel = en ? cnt_q[7:0] : reload_q[7:0]; // RQ8
            SSCC_ADR_BRH: rsel = en ? cnt_q[15:8] : reload_q[15:8]; // RQ8
            default: rsel = 8'h00;
        endcase
    end

    logic txf_q, rxd_q;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= SSCC_BYTE_RST;
            txf_q <= 1'b0;
            rxd_q <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rsel : SSCC_BYTE_RST;
            txf_q <= en && load_now && !auto_reset; // RQ3
            rxd_q <= en && last_latch && !auto_reset; // RQ23
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and pin routing by mode
    assign RDATA = rdata_q;
    assign TX_FREE_IRQ = txf_q;
    assign RX_DONE_IRQ = rxd_q;
    assign ERROR_IRQ = |(err_q & err_en); // RQ12
    assign SCLK_O = mclk_q ^ idle_level_sel; // RQ24
    assign SCLK_OE = en && master; // RQ6
    assign MOSI_O = out_bit_q;
    assign MOSI_OE = en && master; // RQ6
    assign MISO_O = out_bit_q;
    assign MISO_OE = en && !master; // RQ6

endmodule : sscc_core

// ===== sscc_pkg.sv
// Purpose: Shared constants and types for the synchronous serial channel
// Assumes: Module clock CORE_CLK at 125 MHz
// Notes: Register offsets are byte addresses on the plain register port
package sscc_pkg;

    // Register offsets
    localparam logic [3:0] SSCC_ADR_CTRL = 4'h0;
    localparam logic [3:0] SSCC_ADR_STAT = 4'h1;
    localparam logic [3:0] SSCC_ADR_TX = 4'h2;
    localparam logic [3:0] SSCC_ADR_RX = 4'h3;
    localparam logic [3:0] SSCC_ADR_BRL = 4'h4;
    localparam logic [3:0] SSCC_ADR_BRH = 4'h5;

    // Control field positions
    localparam int SSCC_C_EN = 0;
    localparam int SSCC_C_MASTER = 1;
    localparam int SSCC_C_MSB = 2;
    localparam int SSCC_C_PH = 3;
    localparam int SSCC_C_PO = 4;
    localparam int SSCC_C_WLO = 5;
    localparam int SSCC_C_WHI = 7;
    localparam int SSCC_C_REN = 8;
    localparam int SSCC_C_PEN = 9;
    localparam int SSCC_C_BEN = 10;
    localparam int SSCC_C_TEN = 11;

    // Status field positions
    localparam int SSCC_S_RE = 0;
    localparam int SSCC_S_PE = 1;
    localparam int SSCC_S_BE = 2;
    localparam int SSCC_S_TE = 3;
    localparam int SSCC_S_BSY = 4;

    // Reset values
    localparam logic [11:0] SSCC_CTRL_RST = 12'h0E2;
    localparam logic [15:0] SSCC_BRL_RST = 16'h0000;
    localparam logic [7:0] SSCC_BYTE_RST = 8'h00;

    // Phase check window in module clock cycles
    localparam logic [1:0] SSCC_PH_BEFORE = 2'h1;
    localparam logic [1:0] SSCC_PH_AFTER = 2'h2;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sscc_req_t;

endpackage : sscc_pkg

// ===== sscc_core_asserts.sv
// Purpose: Port assertions for the serial channel core
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Enable and reload are shadowed from register writes
module sscc_core_asserts
    import sscc_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Serial clock and enables
    input wire logic SCLK_O,
    input wire logic SCLK_OE,
    input wire logic MOSI_OE,
    input wire logic MISO_OE,
    // Interrupt lines
    input wire logic TX_FREE_IRQ,
    input wire logic RX_DONE_IRQ,
    input wire logic ERROR_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    logic en_q;
    logic sclk_q;
    logic [15:0] rld_q;
    logic [15:0] gap_q;

    // Write decodes, clock edge and saturating gap count
    wire wr_ctrl = WR && (ADDR == SSCC_ADR_CTRL);
    wire wr_stat = WR && (ADDR == SSCC_ADR_STAT);
    wire wr_lo = WR && (ADDR == SSCC_ADR_BRL) && !en_q;
    wire wr_hi = WR && (ADDR == SSCC_ADR_BRH) && !en_q;
    wire toggle = SCLK_O != sclk_q;
    wire [15:0] gap_d = toggle ? 16'h0000
                               : gap_q + {15'h0000, gap_q != 16'hFFFF};

    // Shadow registers
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            en_q <= 1'b0;
            sclk_q <= 1'b0;
            rld_q <= SSCC_BRL_RST;
            gap_q <= 16'h0000;
        end else begin
            if (wr_ctrl) en_q <= WDATA[SSCC_C_EN];
            if (wr_lo) rld_q[7:0] <= WDATA;
            if (wr_hi) rld_q[15:8] <= WDATA;
            sclk_q <= SCLK_O;
            gap_q <= gap_d;
        end
    end

    // Load of the buffer by a master, then the free pulse
    sequence tx_load;
        WR && (ADDR == SSCC_ADR_TX) && SCLK_OE;
    endsequence
    sequence free_seen;
        ##[1:1000] TX_FREE_IRQ;
    endsequence

    chk_free_after_load: assert property (tx_load |-> free_seen)
        else $error("free pulse missing after buffer load");
    chk_free_pulse: assert property (TX_FREE_IRQ |=> !TX_FREE_IRQ)
        else $error("free pulse longer than one cycle");
    chk_done_pulse: assert property (RX_DONE_IRQ |=> !RX_DONE_IRQ)
        else $error("done pulse longer than one cycle");
    chk_master_oe: assert property (wr_ctrl |=>
        SCLK_OE == ($past(WDATA[SSCC_C_EN]) && $past(WDATA[SSCC_C_MASTER]))
        && MOSI_OE == SCLK_OE)
        else $error("master drivers do not follow mode");
    chk_slave_oe: assert property (wr_ctrl |=>
        MISO_OE == ($past(WDATA[SSCC_C_EN]) && !$past(WDATA[SSCC_C_MASTER])))
        else $error("slave driver does not follow mode");
    chk_err_sticky: assert property (ERROR_IRQ && !wr_stat |=> ERROR_IRQ)
        else $error("error line dropped without status write");
    chk_err_masked: assert property (
        wr_stat && WDATA[7:4] == 4'h0 |=> !ERROR_IRQ)
        else $error("error line high with all enables off");
    chk_sclk_spacing: assert property (
        toggle && SCLK_OE && en_q |-> gap_q >= rld_q)
        else $error("shift clock edges closer than reload allows");
    chk_read_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside the read cycle");
endmodule : sscc_core_asserts

bind sscc_core sscc_core_asserts i_chk (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE),
    .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE), .TX_FREE_IRQ(TX_FREE_IRQ),
    .RX_DONE_IRQ(RX_DONE_IRQ), .ERROR_IRQ(ERROR_IRQ)
);

// ===== sscc_partner.sv
// Purpose: Far-side station for the serial channel bench
// Assumes: Open-drain data, line pulled up by the bench
// Notes: Supplies the shift clock when the core is a slave
module sscc_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Frame request and half period in cycles
    input wire logic start,
    input wire logic [7:0] half_cyc,
    // Far-side lines
    output logic sclk_o,
    output logic dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] EDGES = 5'h10; // Eight pulses
    logic [7:0] cnt_q;
    logic [4:0] left_q;

    // Not selected to send: line released, ones only
    assign dat_o = 1'b1;

    // Clock stands idle low outside frames
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            left_q <= 5'h00;
            sclk_o <= 1'b0;
        end else if (start) begin
            cnt_q <= half_cyc;
            left_q <= EDGES;
        end else if (left_q != 5'h00) begin
            if (cnt_q <= 8'h01) begin
                sclk_o <= ~sclk_o;
                left_q <= left_q - 5'h01;
                cnt_q <= half_cyc;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : sscc_partner

// ===== tb_top.sv
// Purpose: Self-checking bench for the serial channel core
// Assumes: Half-duplex data line with pull-up
// Notes: One task per scenario
module tb_top
    import sscc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_b, wr, rd, p_start, p_sclk, p_dat;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, p_half;
    logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic tx_free, rx_done, err_irq;
    int miscompares = 0;
    int n_checks = 0;
    int n_free = 0;
    int n_done = 0;
    // Wired data line and shift clock line
    wire dline = (mosi_oe ? mosi_o : 1'b1) & (miso_oe ? miso_o : 1'b1)
                 & p_dat;
    wire sclk_line = sclk_oe ? sclk_o : p_sclk;

    sscc_core i_dut (
        .CORE_CLK(core_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SCLK_I(sclk_line),
        .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .MOSI_I(dline),
        .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(dline),
        .MISO_O(miso_o), .MISO_OE(miso_oe), .TX_FREE_IRQ(tx_free),
        .RX_DONE_IRQ(rx_done), .ERROR_IRQ(err_irq)
    );
    sscc_partner i_far (.clk(core_clk), .rst_b(rst_b), .start(p_start),
        .half_cyc(p_half), .sclk_o(p_sclk), .dat_o(p_dat));

    //////////////////////////////
    // Clock and pulse counters
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (tx_free === 1'b1) n_free++;
        if (rx_done === 1'b1) n_done++;
    end

    task check(input string w, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", w, e, g);
        end
    endtask : check
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_n(ref int c, input int e);
        repeat (3000) begin
            if (c >= e) break;
            @(posedge core_clk);
        end
        check("pulse count", 8'(e), 8'(c));
    endtask : wait_n
    task automatic spacing(input int n, input int gap);
        int seen = 0;
        int cnt = 0;
        logic prev;
        prev = sclk_o;
        repeat (4000) begin
            @(posedge core_clk);
            #1;
            cnt++;
            if (sclk_o !== prev) begin
                if (seen > 0) check("clock gap", 8'(gap), 8'(cnt));
                seen++;
                prev = sclk_o;
                cnt = 0;
            end
            if (seen >= n) break;
        end
        check("clock edges", 8'(n), 8'(seen));
    endtask : spacing
    task kick(input logic [7:0] h);
        @(posedge core_clk);
        p_half <= h;
        p_start <= 1'b1;
        @(posedge core_clk);
        p_start <= 1'b0;
    endtask : kick

    //////////////////////////////
    // Scenarios
    task t_reset;
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            rd_reg(4'(i), d);
            check("reset read", (4'(i) == SSCC_ADR_CTRL) ? 8'hE2 : 8'h00, d);
        end
        $display("reset test done");
    endtask : t_reset
    task t_master;
        logic [7:0] d;
        logic [7:0] e;
        wr_reg(SSCC_ADR_BRL, 8'h07);
        rd_reg(SSCC_ADR_BRL, d);
        check("reload", 8'h07, d);
        wr_reg(SSCC_ADR_CTRL, 8'hE3);
        wr_reg(SSCC_ADR_TX, 8'hA5);
        spacing(16, 8);
        wait_n(n_done, 1);
        check("free pulses", 8'h01, 8'(n_free));
        rd_reg(SSCC_ADR_RX, d);
        check("own data", 8'hA5, d);
        rd_reg(SSCC_ADR_BRL, d);
        rd_reg(SSCC_ADR_BRL, e);
        check("live count", 8'h01, {7'h00, d <= 8'h07});
        check("live step", (d - 8'h02) & 8'h07, e);
        wr_reg(SSCC_ADR_CTRL, 8'hE2);
        rd_reg(SSCC_ADR_BRL, d);
        check("reload kept", 8'h07, d);
        $display("master test done");
    endtask : t_master
    task t_b2b;
        logic [7:0] d;
        n_free = 0;
        n_done = 0;
        wr_reg(SSCC_ADR_CTRL, 8'hE3);
        wr_reg(SSCC_ADR_STAT, 8'h10);
        wr_reg(SSCC_ADR_TX, 8'h3C);
        wait_n(n_free, 1);
        wr_reg(SSCC_ADR_TX, 8'hC3);
        spacing(30, 8);
        wait_n(n_done, 2);
        rd_reg(SSCC_ADR_STAT, d);
        check("overrun", 8'h11, d);
        check("error line", 8'h01, {7'h00, err_irq});
        rd_reg(SSCC_ADR_RX, d);
        check("overwrite", 8'hC3, d);
        wr_reg(SSCC_ADR_STAT, 8'h01);
        check("masked line", 8'h00, {7'h00, err_irq});
        rd_reg(SSCC_ADR_STAT, d);
        check("flag kept", 8'h01, d);
        wr_reg(SSCC_ADR_STAT, 8'h00);
        rd_reg(SSCC_ADR_STAT, d);
        check("flag cleared", 8'h00, d);
        $display("back to back test done");
    endtask : t_b2b
    task t_phase;
        logic [7:0] d;
        wr_reg(SSCC_ADR_CTRL, 8'hE2);
        wr_reg(SSCC_ADR_BRL, 8'h00);
        wr_reg(SSCC_ADR_STAT, 8'h20);
        wr_reg(SSCC_ADR_CTRL, 8'hE3);
        n_done = 0;
        wr_reg(SSCC_ADR_TX, 8'h5A);
        wait_n(n_done, 1);
        rd_reg(SSCC_ADR_STAT, d);
        check("phase flag", 8'h02, d & 8'h02);
        check("phase line", 8'h01, {7'h00, err_irq});
        $display("phase test done");
    endtask : t_phase
    task t_slave;
        logic [7:0] d;
        wr_reg(SSCC_ADR_CTRL, 8'hE0);
        wr_reg(SSCC_ADR_BRL, 8'h03);
        wr_reg(SSCC_ADR_STAT, 8'h80);
        wr_reg(SSCC_ADR_CTRL, 8'hE1);
        check("slave oe", 8'h01, {5'h00, sclk_oe, mosi_oe, miso_oe});
        n_done = 0;
        kick(8'h04);
        wait_n(n_done, 1);
        repeat (20) @(posedge core_clk);
        rd_reg(SSCC_ADR_STAT, d);
        check("stale flags", 8'h0C, d & 8'h0C);
        check("stale line", 8'h01, {7'h00, err_irq});
        wr_reg(SSCC_ADR_CTRL, 8'hE0);
        wr_reg(SSCC_ADR_STAT, 8'h40);
        wr_reg(SSCC_ADR_TX, 8'h96);
        wr_reg(SSCC_ADR_CTRL, 8'hE1);
        rd_reg(SSCC_ADR_STAT, d);
        check("rate clear", 8'h00, d & 8'h0C);
        kick(8'h0C);
        repeat (400) begin
            @(posedge core_clk);
            if (err_irq === 1'b1) break;
        end
        rd_reg(SSCC_ADR_STAT, d);
        check("rate flag", 8'h04, d & 8'h0C);
        check("rate line", 8'h01, {7'h00, err_irq});
        $display("slave test done");
    endtask : t_slave

    task results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        rst_b = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        p_start = 1'b0;
        p_half = 8'h04;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_master();
        t_b2b();
        t_phase();
        t_slave();
        results();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        $display("watchdog expired");
        results();
    end
endmodule : tb_top
